// file: logic/csm_device.sv
// codec end: serial clock source, word interpreter, control registers
// assumes the host drives input frame sync and data on serial clock falls
// How it works
// - non-loop host sends after device word ends
// - input frame sync pulse starts incoming word
// - register A mixed plus select bits: mixed
// - mixed mode checks received word msb
// - bit 14 set means register readback
// - readback loads shifter, raises output sync
// - readback address field goes zero to 111
// - looped syncs allow one word per period
// - non-loop accepts control and dac per period
// - host sends cascade control words gaplessly
// - register B sets clock, rate, sclk divisors
// - register C holds section power-up bits
// - sample word still sent while adc off
// - mode applies regardless of power state
// - output sync raised each sample event unless a forwarded or readback word holds the pending slot
// - nonzero address decremented, passed down cascade
// - zero address loads low byte to register
// - data mode words are dac, adc
// - data mode counts syncs to device count
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module csm_device import csm_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        presetn,
    csm_link_if.device       link,
    input  wire logic [15:0] adc_sample,
    output logic      [15:0] dac_word,
    output logic             dac_load,
    output logic      [7:0]  ctrl_a,
    output logic      [7:0]  ctrl_b,
    output logic      [7:0]  ctrl_c
);
    // ----------------------------------------
    // registers and mode
    // ----------------------------------------
    logic [7:0]  ctla_q;
    logic [7:0]  ctlb_q;
    logic [7:0]  ctlc_q;
    csm_mode_t   mode;
    // mode only looks at register A, never at power bits
    always_comb begin
        if (!ctla_q[CTLA_PGMD]) begin
            mode = CSM_PROGRAM;
        end else if (ctla_q[CTLA_MIX]) begin
            mode = CSM_MIXED;
        end else begin
            mode = CSM_DATA;
        end
    end

    // ----------------------------------------
    // clock dividers
    // ----------------------------------------
    logic [4:0]  mdiv_q;
    logic [4:0]  mdiv_lim;
    logic        dm_tick;
    logic [3:0]  sdiv_q;
    logic [3:0]  sdiv_lim;
    logic        tog;
    logic        sclk_q;
    logic        rise;
    logic        fall;
    logic [10:0] sr_q;
    logic [10:0] sr_lim;
    logic        sample_evt;
    // base keeps half a serial period at four clocks or more
    assign mdiv_lim = 5'(DIVCLK_BASE * (int'(ctlb_q[CTLB_MDIV_LO +: 2]) + 1) - 1);
    assign sdiv_lim = 4'((1 << ctlb_q[CTLB_SDIV_LO +: 2]) - 1);
    assign sr_lim   = 11'((SR_BASE << ctlb_q[CTLB_SR_LO +: 2]) - 1);
    assign dm_tick  = (mdiv_q == mdiv_lim);
    assign tog      = dm_tick && (sdiv_q == sdiv_lim);
    assign rise     = tog && !sclk_q;
    assign fall     = tog && sclk_q;
    assign sample_evt = dm_tick && (sr_q == sr_lim);

    // divided master clock enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdiv_q <= 5'h00;
        end else if (dm_tick || mdiv_q > mdiv_lim) begin
            mdiv_q <= 5'h00;
        end else begin
            mdiv_q <= mdiv_q + 5'h01;
        end
    end

    // serial clock toggles every sdiv_lim + 1 divided ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdiv_q <= 4'h0;
            sclk_q <= 1'b0;
        end else if (dm_tick) begin
            if (sdiv_q >= sdiv_lim) begin
                sdiv_q <= 4'h0;
                sclk_q <= !sclk_q;
            end else begin
                sdiv_q <= sdiv_q + 4'h1;
            end
        end
    end

    // sample period counter on divided clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_q <= 11'h000;
        end else if (dm_tick) begin
            sr_q <= (sr_q >= sr_lim) ? 11'h000 : sr_q + 11'h001;
        end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    logic [15:0] rx_sr_q;
    logic [4:0]  rx_cnt_q;
    logic        rx_done;
    logic [15:0] rx_word;
    assign rx_word = {rx_sr_q[14:0], link.device_data_in};
    assign rx_done = rise && (rx_cnt_q == 5'h01);

    // frame begins when input sync is seen on a rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sr_q  <= 16'h0000;
            rx_cnt_q <= 5'h00;
        end else if (rise) begin
            if (rx_cnt_q != 5'h00) begin
                rx_sr_q  <= rx_word;
                rx_cnt_q <= rx_cnt_q - 5'h01;
            end else if (link.input_frame_sync) begin
                rx_sr_q  <= {15'h0000, link.device_data_in};
                rx_cnt_q <= 5'(WORD_W - 1);
            end
        end
    end

    // ----------------------------------------
    // word interpretation
    // ----------------------------------------
    logic        is_ctl;
    logic [2:0]  dev_addr;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_val;
    logic [2:0]  fs_cnt_q;
    logic [2:0]  dev_cnt;
    logic        cnt_hit;
    logic        fwd;
    logic        rdbk;
    logic        wr;
    logic        dac_hit;
    logic [15:0] send_word;
    logic [15:0] dec_word;
    assign dev_addr = rx_word[DEVA_HI:DEVA_LO];
    assign reg_addr = rx_word[REGA_HI:REGA_LO];
    assign dev_cnt  = (ctla_q[CTLA_CNT_LO +: 3] == 3'h0) ? 3'h1 : ctla_q[CTLA_CNT_LO +: 3];
    assign cnt_hit  = (fs_cnt_q + 3'h1 == dev_cnt);
    assign dec_word = {rx_word[15:14], dev_addr - 3'h1, rx_word[10:0]};

    // readback source
    always_comb begin
        if (reg_addr == REG_A) begin
            reg_val = ctla_q;
        end else if (reg_addr == REG_B) begin
            reg_val = ctlb_q;
        end else if (reg_addr == REG_C) begin
            reg_val = ctlc_q;
        end else begin
            reg_val = 8'h00;
        end
    end

    // classify a completed word
    always_comb begin
        is_ctl    = 1'b0;
        fwd       = 1'b0;
        rdbk      = 1'b0;
        wr        = 1'b0;
        dac_hit   = 1'b0;
        send_word = dec_word;
        case (mode)
            CSM_PROGRAM: is_ctl = 1'b1;
            CSM_MIXED:   is_ctl = rx_word[CTL_BIT];
            default:     is_ctl = 1'b0;
        endcase
        if (rx_done) begin
            if (is_ctl && dev_addr != 3'h0) begin
                fwd = 1'b1;
            end else if (is_ctl && rx_word[RDBK_BIT]) begin
                rdbk      = 1'b1;
                send_word = {2'b11, 3'h0 - 3'h1, reg_addr, reg_val};
            end else if (is_ctl) begin
                wr = 1'b1;
            end else if (mode == CSM_MIXED || cnt_hit) begin
                dac_hit = 1'b1;
            end else begin
                fwd       = 1'b1;
                send_word = rx_word;
            end
        end
    end

    // control register writes take the low byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctla_q <= CTLA_RST;
            ctlb_q <= CTLB_RST;
            ctlc_q <= CTLC_RST;
        end else if (wr) begin
            if (reg_addr == REG_A) begin
                ctla_q <= rx_word[7:0];
            end else if (reg_addr == REG_B) begin
                ctlb_q <= rx_word[7:0];
            end else if (reg_addr == REG_C) begin
                ctlc_q <= rx_word[7:0];
            end
        end
    end

    // data mode sync counter, cleared outside data mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_cnt_q <= 3'h0;
        end else if (mode != CSM_DATA) begin
            fs_cnt_q <= 3'h0;
        end else if (rx_done) begin
            fs_cnt_q <= cnt_hit ? 3'h0 : fs_cnt_q + 3'h1;
        end
    end

    // dac register and load strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_word <= 16'h0000;
            dac_load <= 1'b0;
        end else begin
            dac_load <= dac_hit;
            if (dac_hit) begin
                dac_word <= rx_word;
            end
        end
    end

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    logic [15:0] echo_q;
    logic [15:0] sample_word;
    logic        pend_q;
    logic [15:0] pend_word_q;
    logic [15:0] tx_sr_q;
    logic [4:0]  tx_cnt_q;
    logic        ofs_q;
    logic        sdo_q;
    logic        start;
    assign start = fall && (tx_cnt_q == 5'h00) && pend_q;
    // program mode echoes the last word; outside program mode a zero word is sent while the adc is off
    assign sample_word = (mode == CSM_PROGRAM) ? echo_q :
                         (ctlc_q[CTLC_ADC] ? adc_sample : 16'h0000);

    // address-decremented copy of last control word in program mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            echo_q <= 16'h0000;
        end else if (rx_done && mode == CSM_PROGRAM) begin
            echo_q <= dec_word;
        end
    end

    // one pending slot; forwarded words beat a sample in the same slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q      <= 1'b0;
            pend_word_q <= 16'h0000;
        end else if (fwd || rdbk) begin
            pend_q      <= 1'b1;
            pend_word_q <= send_word;
        end else if (sample_evt && (!pend_q || start)) begin
            pend_q      <= 1'b1;
            pend_word_q <= sample_word;
        end else if (start) begin
            pend_q <= 1'b0;
        end
    end

    // shift out msb first, back to back words allowed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sr_q  <= 16'h0000;
            tx_cnt_q <= 5'h00;
            ofs_q    <= 1'b0;
            sdo_q    <= 1'b0;
        end else if (fall) begin
            if (tx_cnt_q != 5'h00) begin
                ofs_q    <= 1'b0;
                sdo_q    <= tx_sr_q[15];
                tx_sr_q  <= {tx_sr_q[14:0], 1'b0};
                tx_cnt_q <= tx_cnt_q - 5'h01;
            end else if (pend_q) begin
                ofs_q    <= 1'b1;
                sdo_q    <= pend_word_q[15];
                tx_sr_q  <= {pend_word_q[14:0], 1'b0};
                tx_cnt_q <= 5'(WORD_W - 1);
            end else begin
                ofs_q <= 1'b0;
                sdo_q <= 1'b0;
            end
        end
    end

    assign link.serial_clock      = sclk_q;
    assign link.output_frame_sync = ofs_q;
    assign link.device_data_out   = sdo_q;
    assign ctrl_a = ctla_q;
    assign ctrl_b = ctlb_q;
    assign ctrl_c = ctlc_q;
endmodule : csm_device
`default_nettype wire

// file: logic/csm_host.sv
// host serial port end with apb registers for software
// assumes the codec makes the serial clock; all pins on pclk
`timescale 1ns/100ps
`default_nettype none
module csm_host import csm_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        presetn,
    csm_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    // ----------------------------------------
    // apb slave, one wait-free access phase
    // ----------------------------------------
    logic        loop_q;
    logic [15:0] tx_word_q;
    logic        tx_pend_q;
    logic [15:0] rx_word_q;
    logic        rx_valid_q;
    logic [4:0]  rx_cnt_q;
    logic [4:0]  tx_cnt_q;
    logic        setup;
    logic        acc;
    logic        mapped;
    assign setup  = psel && !penable;
    assign acc    = psel && penable && pready;
    assign mapped = (paddr == HOST_CTRL) || (paddr == HOST_TX) ||
                    (paddr == HOST_STAT) || (paddr == HOST_RX);

    // read data captured in setup so every output is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                if (paddr == HOST_CTRL) begin
                    prdata <= {31'h00000000, loop_q};
                end else if (paddr == HOST_TX) begin
                    prdata <= {16'h0000, tx_word_q};
                end else if (paddr == HOST_STAT) begin
                    prdata <= {28'h0000000, tx_cnt_q != 5'h00, rx_cnt_q != 5'h00,
                               rx_valid_q, tx_pend_q};
                end else if (paddr == HOST_RX) begin
                    prdata <= {16'h0000, rx_word_q};
                end else begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end

    // ----------------------------------------
    // serial engine
    // ----------------------------------------
    logic        sclk_prev_q;
    logic        rise;
    logic        fall;
    logic        seen_q;
    logic        go;
    logic        rx_done;
    logic [15:0] rx_sr_q;
    logic [15:0] tx_sr_q;
    logic        ifs_q;
    logic        sdi_q;
    assign rise    = link.serial_clock && !sclk_prev_q;
    assign fall    = !link.serial_clock && sclk_prev_q;
    assign rx_done = rise && (rx_cnt_q == 5'h01);
    // looped: one word per device sync; else wait for its word to end
    assign go = fall && (tx_cnt_q == 5'h00) && tx_pend_q &&
                (loop_q ? seen_q : (rx_cnt_q == 5'h00));

    // control bit, tx word; pend set by write wins over clear by start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_q    <= 1'b0;
            tx_word_q <= 16'h0000;
            tx_pend_q <= 1'b0;
        end else if (acc && pwrite && paddr == HOST_TX) begin
            tx_word_q <= pwdata[15:0];
            tx_pend_q <= 1'b1;
        end else begin
            if (acc && pwrite && paddr == HOST_CTRL) begin
                loop_q <= pwdata[CTRL_LOOP];
            end
            if (go) begin
                tx_pend_q <= 1'b0;
            end
        end
    end

    // receive on rises; reading rx clears valid unless a word lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev_q <= 1'b0;
            rx_sr_q     <= 16'h0000;
            rx_cnt_q    <= 5'h00;
            rx_word_q   <= 16'h0000;
            rx_valid_q  <= 1'b0;
            seen_q      <= 1'b0;
        end else begin
            sclk_prev_q <= link.serial_clock;
            if (rx_done) begin
                rx_word_q  <= {rx_sr_q[14:0], link.device_data_out};
                rx_valid_q <= 1'b1;
            end else if (acc && !pwrite && paddr == HOST_RX) begin
                rx_valid_q <= 1'b0;
            end
            if (rise && rx_cnt_q != 5'h00) begin
                rx_sr_q  <= {rx_sr_q[14:0], link.device_data_out};
                rx_cnt_q <= rx_cnt_q - 5'h01;
            end else if (rise && link.output_frame_sync) begin
                rx_sr_q  <= {15'h0000, link.device_data_out};
                rx_cnt_q <= 5'(WORD_W - 1);
            end
            if (rise && link.output_frame_sync) begin
                seen_q <= 1'b1;
            end else if (go) begin
                seen_q <= 1'b0;
            end
        end
    end

    // transmit on falls with sync on the first bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sr_q  <= 16'h0000;
            tx_cnt_q <= 5'h00;
            ifs_q    <= 1'b0;
            sdi_q    <= 1'b0;
        end else if (fall) begin
            if (tx_cnt_q != 5'h00) begin
                ifs_q    <= 1'b0;
                sdi_q    <= tx_sr_q[15];
                tx_sr_q  <= {tx_sr_q[14:0], 1'b0};
                tx_cnt_q <= tx_cnt_q - 5'h01;
            end else if (go) begin
                ifs_q    <= 1'b1;
                sdi_q    <= tx_word_q[15];
                tx_sr_q  <= {tx_word_q[14:0], 1'b0};
                tx_cnt_q <= 5'(WORD_W - 1);
            end else begin
                ifs_q <= 1'b0;
                sdi_q <= 1'b0;
            end
        end
    end

    assign link.input_frame_sync = ifs_q;
    assign link.device_data_in   = sdi_q;
endmodule : csm_host
`default_nettype wire

// file: logic/csm_link_if.sv
// serial link between codec and host port
// assumes all pins are sampled on pclk by both ends
`timescale 1ns/100ps
`default_nettype none
interface csm_link_if;
    logic serial_clock;
    logic output_frame_sync;
    logic device_data_out;
    logic input_frame_sync;
    logic device_data_in;
    modport device (output serial_clock, output output_frame_sync,
                    output device_data_out, input input_frame_sync,
                    input device_data_in);
    modport host (input serial_clock, input output_frame_sync,
                  input device_data_out, output input_frame_sync,
                  output device_data_in);
endinterface : csm_link_if
`default_nettype wire

// file: logic/csm_pkg.sv
// constants shared by both ends of the codec serial link
// assumes one 50 MHz clock and sixteen-bit frames
package csm_pkg;
    // ----------------------------------------
    // word layout
    // ----------------------------------------
    localparam int        WORD_W    = 16;
    localparam int        CTL_BIT   = 15;
    localparam int        RDBK_BIT  = 14;
    localparam int        DEVA_HI   = 13;
    localparam int        DEVA_LO   = 11;
    localparam int        REGA_HI   = 10;
    localparam int        REGA_LO   = 8;
    localparam logic [2:0] REG_A    = 3'h0;
    localparam logic [2:0] REG_B    = 3'h1;
    localparam logic [2:0] REG_C    = 3'h2;
    // ----------------------------------------
    // control register fields and resets
    // ----------------------------------------
    localparam int        CTLA_PGMD  = 0;
    localparam int        CTLA_MIX   = 1;
    localparam int        CTLA_CNT_LO = 5;
    localparam int        CTLB_MDIV_LO = 0;
    localparam int        CTLB_SDIV_LO = 2;
    localparam int        CTLB_SR_LO = 4;
    localparam int        CTLC_ADC   = 0;
    localparam int        CTLC_DAC   = 1;
    localparam int        CTLC_REF   = 2;
    localparam int        CTLC_REFO  = 3;
    localparam logic [7:0] CTLA_RST  = 8'h00;
    localparam logic [7:0] CTLB_RST  = 8'h00;
    localparam logic [7:0] CTLC_RST  = 8'h00;
    // ----------------------------------------
    // timing counts in clock and divided ticks
    // ----------------------------------------
    localparam int        DIVCLK_BASE = 4;
    localparam int        SR_BASE   = 256;
    // ----------------------------------------
    // host register map
    // ----------------------------------------
    localparam logic [7:0] HOST_CTRL = 8'h00;
    localparam logic [7:0] HOST_TX  = 8'h04;
    localparam logic [7:0] HOST_STAT = 8'h08;
    localparam logic [7:0] HOST_RX  = 8'h0C;
    localparam int        CTRL_LOOP = 0;
    localparam int        ST_TXP    = 0;
    localparam int        ST_RXV    = 1;
    localparam int        ST_RXB    = 2;
    localparam int        ST_TXB    = 3;
    typedef enum logic [1:0] {CSM_PROGRAM, CSM_DATA, CSM_MIXED} csm_mode_t;
endpackage : csm_pkg

// file: testbench/csm_link_checker.sv
// link checker: watches the serial wires between codec and host
// assumes default divisors, four pclk per serial clock half
`timescale 1ns/100ps
`default_nettype none
module csm_link_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic serial_clock,
    input wire logic output_frame_sync,
    input wire logic device_data_out,
    input wire logic input_frame_sync,
    input wire logic device_data_in
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    logic [7:0] age_q;
    // cycles since last device sync; saturates so idle links stay legal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) age_q <= 8'hFF;
        else if ($rose(output_frame_sync)) age_q <= 8'h00;
        else if (age_q != 8'hFF) age_q <= age_q + 8'h01;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_sclk_high; $rose(serial_clock) |-> serial_clock[*4] ##1 !serial_clock; endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("serial clock high phase");
    property p_sclk_low; $fell(serial_clock) |-> !serial_clock[*4] ##1 serial_clock; endproperty
    a_sclk_low: assert property (p_sclk_low) else $error("serial clock low phase");
    property p_osync_len;
        $rose(output_frame_sync) |-> output_frame_sync[*8] ##1 !output_frame_sync;
    endproperty
    a_osync_len: assert property (p_osync_len) else $error("device sync length");
    property p_osync_hold; serial_clock && $past(serial_clock) |-> $stable(output_frame_sync);
    endproperty
    a_osync_hold: assert property (p_osync_hold) else $error("device sync moved");
    property p_dout_hold; serial_clock && $past(serial_clock) |-> $stable(device_data_out);
    endproperty
    a_dout_hold: assert property (p_dout_hold) else $error("device data moved");
    property p_isync_len; $rose(input_frame_sync) |-> input_frame_sync[*8] ##1 !input_frame_sync;
    endproperty
    a_isync_len: assert property (p_isync_len) else $error("host sync length");
    property p_din_hold; serial_clock && $past(serial_clock) |-> $stable(device_data_in);
    endproperty
    a_din_hold: assert property (p_din_hold) else $error("host data moved");
    property p_word_gap; $rose(output_frame_sync) |-> age_q >= 8'h7F; endproperty
    a_word_gap: assert property (p_word_gap) else $error("device word cut short");
    property p_host_wait; $rose(input_frame_sync) |-> age_q > 8'h78; endproperty
    a_host_wait: assert property (p_host_wait) else $error("host sent while busy");
    c_dev_word: cover property ($rose(output_frame_sync));
    c_host_word: cover property ($rose(input_frame_sync));
    c_reply: cover property ($rose(input_frame_sync) ##[1:400] $rose(output_frame_sync));
endmodule : csm_link_checker
`default_nettype wire

// file: testbench/tb.sv
// bench: host and codec ends joined by the link, driven over apb
// assumes default divisors, so a sample period is 1024 pclk
`timescale 1ns/100ps
`default_nettype none
module tb import csm_pkg::*; ();
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic [15:0] adc_sample = 16'h5A5A, dac_word;
    logic        dac_load;
    logic [7:0]  ctrl_a, ctrl_b, ctrl_c;
    int          miscompares = 0, compares = 0, cyc = 0, loads = 0;
    csm_link_if csm_link_if_i ();
    csm_device csm_device_i (.pclk(pclk), .presetn(presetn), .link(csm_link_if_i),
        .adc_sample(adc_sample), .dac_word(dac_word), .dac_load(dac_load),
        .ctrl_a(ctrl_a), .ctrl_b(ctrl_b), .ctrl_c(ctrl_c));
    csm_host csm_host_i (.pclk(pclk), .presetn(presetn), .link(csm_link_if_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    csm_link_checker csm_link_checker_i (.pclk(pclk), .presetn(presetn),
        .serial_clock(csm_link_if_i.serial_clock),
        .output_frame_sync(csm_link_if_i.output_frame_sync),
        .device_data_out(csm_link_if_i.device_data_out),
        .input_frame_sync(csm_link_if_i.input_frame_sync),
        .device_data_in(csm_link_if_i.device_data_in));
    // ----------------------------------------
    // clock, ceiling and helpers
    // ----------------------------------------
    always #10 pclk = ~pclk;
    // a hang is cut short; dac load pulses are tallied
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (dac_load === 1'b1) loads <= loads + 1;
        if (cyc == 60000) begin
            miscompares = miscompares + 1;
            test_done();
        end
    end
    task automatic test_done();
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; result left in rd and err
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // poll status until a word is held, then take it
    task automatic get_rx();
        rd = 32'h0;
        while (rd[ST_RXV] !== 1'b1) apb(1'b0, HOST_STAT, 32'h0);
        apb(1'b0, HOST_RX, 32'h0);
    endtask : get_rx
    // send just after a fresh word, so the reply is not mixed with a stale one
    task automatic step(input logic [15:0] w, input logic [15:0] exp);
        apb(1'b0, HOST_RX, 32'h0);
        get_rx();
        apb(1'b1, HOST_TX, {16'h0000, w});
        get_rx();
        chk({16'h0000, rd[15:0]}, {16'h0000, exp});
    endtask : step
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_unmapped();
        apb(1'b0, 8'hF0, 32'h0);
        chk({31'h0, err}, 32'h00000001);
        chk(rd, 32'h00000000);
        apb(1'b1, HOST_CTRL, 32'h0);
        apb(1'b0, HOST_CTRL, 32'h0);
        chk(rd, 32'h00000000);
    endtask : t_unmapped
    task automatic t_program();
        step(16'h820F, 16'hBA0F);
        chk({24'h0, ctrl_c}, 32'h0000000F);
        step(16'hC200, 16'hFA0F);
        step(16'h8A05, 16'h8205);
        chk({24'h0, ctrl_c}, 32'h0000000F);
        chk({24'h0, ctrl_b}, 32'h00000000);
    endtask : t_program
    task automatic t_mixed();
        step(16'h8003, 16'h5A5A);
        chk({24'h0, ctrl_a}, 32'h00000003);
        step(16'h1234, 16'h5A5A);
        chk({16'h0, dac_word}, 32'h00001234);
        chk(loads, 32'h00000001);
        step(16'h820E, 16'h0000);
        chk({24'h0, ctrl_a}, 32'h00000003);
    endtask : t_mixed
    task automatic t_data();
        step(16'h8001, 16'h0000);
        step(16'h8123, 16'h0000);
        chk({16'h0, dac_word}, 32'h00008123);
        chk(loads, 32'h00000002);
        chk({24'h0, ctrl_a}, 32'h00000001);
    endtask : t_data
    // reset, then the scenarios in mode order
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_unmapped();
        t_program();
        t_mixed();
        t_data();
        test_done();
    end
endmodule : tb
`default_nettype wire
